// ==== verilog/pfm_pkg.sv ====
`default_nettype none
package pfm_pkg;
   // Register bus
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] ADDR_PAD_FUNCTION_SELECT = 32'hD003_0030;
   localparam int unsigned SEL_W = 29;
   localparam logic [SEL_W-1:0] SEL_RESET = 29'h0000000;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h00000000;

   // Select bit positions
   localparam int unsigned NAV_CLOCK_PAD_SELECT = 28;
   localparam int unsigned NAV_MODE2_PAD_SELECT = 27;
   localparam int unsigned NAV_MODE1_PAD_SELECT = 26;
   localparam int unsigned NAV_MODE0_PAD_SELECT = 25;
   localparam int unsigned NAV_SERIAL_PAD_SELECT = 24;
   localparam int unsigned SECOND_SERIAL_SELECT = 23;
   localparam int unsigned SECOND_STREAM_PORT_SELECT = 22;
   localparam int unsigned POWER_IFACE_SELECT = 21;
   localparam int unsigned SPI_SELECT_THREE_ENABLE = 20;
   localparam int unsigned SPI_SELECT_TWO_ENABLE = 19;
   localparam int unsigned SPI_SELECT_ONE_ENABLE = 18;
   localparam int unsigned CARD_BUS_SELECT = 17;
   localparam int unsigned REF_CLOCK_TX_SELECT = 16;
   localparam int unsigned CLOCK_OBS_D3_SELECT = 15;
   localparam int unsigned KEY_DRIVE3_SELECT = 11;
   localparam int unsigned KEY_SENSE3_SELECT = 7;
   localparam int unsigned DISPLAY_BIT17_PAD_SELECT = 3;
   localparam int unsigned DISPLAY_BIT16_PAD_SELECT = 2;
   localparam int unsigned AUDIO_FSR_PWM_SELECT = 1;
   localparam int unsigned SMARTCARD_CTRL_PAD_SELECT = 0;

   // Pad indexes
   localparam int unsigned PAD_STREAM_CLOCK = 0;
   localparam int unsigned PAD_UART_RTS = 1;
   localparam int unsigned PAD_STREAM_SYNC = 2;
   localparam int unsigned PAD_STREAM_VALID = 3;
   localparam int unsigned PAD_STREAM_DATA = 4;
   localparam int unsigned PAD_DISP_D22 = 5;
   localparam int unsigned PAD_DISP_D23 = 6;
   localparam int unsigned PAD_SPI2_CLOCK = 7;
   localparam int unsigned PAD_SPI2_SELECT = 8;
   localparam int unsigned PAD_SPI2_TX = 9;
   localparam int unsigned PAD_SPI2_RX = 10;
   localparam int unsigned PAD_SPARE3 = 11;
   localparam int unsigned PAD_SPARE4 = 12;
   localparam int unsigned PAD_SPARE15 = 13;
   localparam int unsigned PAD_SMARTCARD_VOLTAGE = 14;
   localparam int unsigned PAD_FLASH_CE4 = 15;
   localparam int unsigned PAD_UART_CTS = 16;
   localparam int unsigned PAD_FLASH_CE3 = 17;
   localparam int unsigned PAD_FLASH_D0 = 18;
   localparam int unsigned FLASH_DATA_W = 8;
   localparam int unsigned PAD_FLASH_CE1 = 26;
   localparam int unsigned PAD_FLASH_CE2 = 27;
   localparam int unsigned PAD_UART_TX = 28;
   localparam int unsigned PAD_CARD_D3 = 29;
   localparam int unsigned PAD_SPARE14 = 33;
   localparam int unsigned PAD_SPARE10 = 37;
   localparam int unsigned GROUP4_W = 4;
   localparam int unsigned PAD_DISP_D17 = 41;
   localparam int unsigned PAD_DISP_D16 = 42;
   localparam int unsigned PAD_AUDIO_FSR = 43;
   localparam int unsigned PAD_SMARTCARD_CTRL = 44;
   localparam int unsigned NUM_PADS = 45;

   // Alternate indexes: one per pad, plus the second choice on the RTS pad
   localparam int unsigned ALT_SPI_SELECT_TWO = 45;
   localparam int unsigned NUM_ALTS = 46;

   // Complete state of the routing stage
   typedef struct packed {
      logic [NUM_PADS-1:0] sync1;
      logic [NUM_PADS-1:0] sync2;
      logic [NUM_PADS-1:0] pad_out;
      logic [NUM_PADS-1:0] pad_oe;
      logic [NUM_PADS-1:0] pad_alt;
      logic [NUM_PADS-1:0] main_in;
      logic [NUM_ALTS-1:0] alt_in;
   } pfm_route_t;

   // Complete state of the register slave
   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic [DATA_W-1:0] rdata;
   } pfm_regs_t;
endpackage
`default_nettype wire

// ==== verilog/pfm_reg_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pfm_reg_if;
   import pfm_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic write;
   logic read;
   logic [DATA_W-1:0] rdata;
   logic [SEL_W-1:0] sel;
   // Side that issues accesses and uses the selection
   modport host (output addr, output wdata, output write, output read,
      input rdata, input sel);
   // Side that holds the selection register
   modport regs (input addr, input wdata, input write, input read,
      output rdata, output sel);
endinterface
`default_nettype wire

// ==== verilog/pfm_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfm_regs
   import pfm_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   pfm_reg_if.regs bus
);
   pfm_regs_t cur_ff;
   pfm_regs_t nxt_ff;
   logic hit;

   // Single mapped word
   assign hit = (bus.addr == ADDR_PAD_FUNCTION_SELECT);

   // Write stores the selection, read answers one cycle later
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.rdata = RDATA_IDLE;
      if (bus.write && hit) begin
         nxt_ff.sel = bus.wdata[SEL_W-1:0]; // Upper bits dropped
      end
      if (bus.read && hit) begin
         nxt_ff.rdata = {{(DATA_W-SEL_W){1'b0}}, cur_ff.sel};
      end
   end

   // State register, main functions after reset
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         cur_ff.sel <= SEL_RESET;
         cur_ff.rdata <= RDATA_IDLE;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign bus.rdata = cur_ff.rdata;
   assign bus.sel = cur_ff.sel;
endmodule // pfm_regs
`default_nettype wire

// ==== verilog/pfm_pad_mux.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_mux
   import pfm_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WRITE,
   input wire logic I_READ,
   output logic [DATA_W-1:0] O_RDATA,
   input wire logic [NUM_PADS-1:0] I_PAD_IN,
   output logic [NUM_PADS-1:0] O_PAD_OUT,
   output logic [NUM_PADS-1:0] O_PAD_OE,
   output logic [NUM_PADS-1:0] O_PAD_ALT,
   input wire logic [NUM_PADS-1:0] I_MAIN_OUT,
   input wire logic [NUM_PADS-1:0] I_MAIN_OE,
   output logic [NUM_PADS-1:0] O_MAIN_IN,
   input wire logic [NUM_ALTS-1:0] I_ALT_OUT,
   input wire logic [NUM_ALTS-1:0] I_ALT_OE,
   output logic [NUM_ALTS-1:0] O_ALT_IN
);
   // Select bit that moves a pad to its first alternate
   function automatic int unsigned alt_bit(input int unsigned p);
      int unsigned b;
      b = SMARTCARD_CTRL_PAD_SELECT;
      case (p)
         // Navigation receiver on the stream pads and the RTS pad
         PAD_STREAM_CLOCK: begin
            b = NAV_CLOCK_PAD_SELECT;
         end
         PAD_UART_RTS: begin
            b = NAV_MODE2_PAD_SELECT;
         end
         PAD_STREAM_SYNC: begin
            b = NAV_MODE1_PAD_SELECT;
         end
         PAD_STREAM_VALID: begin
            b = NAV_MODE0_PAD_SELECT;
         end
         PAD_STREAM_DATA: begin
            b = NAV_SERIAL_PAD_SELECT;
         end
         // Second serial port on display data 22 and 23
         PAD_DISP_D22, PAD_DISP_D23: begin
            b = SECOND_SERIAL_SELECT;
         end
         // Second stream port on the second SPI port
         PAD_SPI2_CLOCK, PAD_SPI2_SELECT, PAD_SPI2_TX, PAD_SPI2_RX: begin
            b = SECOND_STREAM_PORT_SELECT;
         end
         // Power interface on two spare pads
         PAD_SPARE3, PAD_SPARE4: begin
            b = POWER_IFACE_SELECT;
         end
         // Extra SPI devices
         PAD_SPARE15, PAD_SMARTCARD_VOLTAGE: begin
            b = SPI_SELECT_THREE_ENABLE;
         end
         PAD_FLASH_CE4: begin
            b = SPI_SELECT_TWO_ENABLE;
         end
         PAD_UART_CTS, PAD_FLASH_CE3: begin
            b = SPI_SELECT_ONE_ENABLE;
         end
         // Card bus on the flash enables
         PAD_FLASH_CE1, PAD_FLASH_CE2: begin
            b = CARD_BUS_SELECT;
         end
         // Reference clock on the serial transmit pad
         PAD_UART_TX: begin
            b = REF_CLOCK_TX_SELECT;
         end
         // Secondary I2C on display data 17 and 16
         PAD_DISP_D17: begin
            b = DISPLAY_BIT17_PAD_SELECT;
         end
         PAD_DISP_D16: begin
            b = DISPLAY_BIT16_PAD_SELECT;
         end
         // PWM outputs
         PAD_AUDIO_FSR: begin
            b = AUDIO_FSR_PWM_SELECT;
         end
         PAD_SMARTCARD_CTRL: begin
            b = SMARTCARD_CTRL_PAD_SELECT;
         end
         default: begin
            // Ranges: flash data, clock observation, keypad lines
            if (p >= PAD_FLASH_D0 && p < PAD_FLASH_D0 + FLASH_DATA_W) begin
               b = CARD_BUS_SELECT;
            end else if (p >= PAD_CARD_D3 &&
                         p < PAD_CARD_D3 + GROUP4_W) begin
               b = CLOCK_OBS_D3_SELECT - (p - PAD_CARD_D3);
            end else if (p >= PAD_SPARE14 &&
                         p < PAD_SPARE14 + GROUP4_W) begin
               b = KEY_DRIVE3_SELECT - (p - PAD_SPARE14);
            end else if (p >= PAD_SPARE10 &&
                         p < PAD_SPARE10 + GROUP4_W) begin
               b = KEY_SENSE3_SELECT - (p - PAD_SPARE10);
            end
         end
      endcase
      return b;
   endfunction

   pfm_reg_if u_bus ();
   pfm_route_t cur_ff;
   pfm_route_t nxt_ff;
   logic [NUM_PADS-1:0] take_first;
   logic take_second;

   // Bus ports onto the register carrier
   assign u_bus.addr = I_ADDR;
   assign u_bus.wdata = I_WDATA;
   assign u_bus.write = I_WRITE;
   assign u_bus.read = I_READ;
   assign O_RDATA = u_bus.rdata;

   // Selection register
   pfm_regs u_regs (
      .i_clock(I_CLOCK),
      .i_reset(I_RESET),
      .bus(u_bus.regs)
   );

   // Per-pad first alternate request
   genvar g;
   generate
      for (g = 0; g < NUM_PADS; g++) begin : g_first
         assign take_first[g] = u_bus.sel[alt_bit(g)];
      end
   endgenerate

   // RTS pad: navigation mode two wins over SPI select two
   assign take_second = !take_first[PAD_UART_RTS] &&
      u_bus.sel[SPI_SELECT_TWO_ENABLE];

   // Synchronise pads, then route each pad to one owner
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.sync1 = I_PAD_IN;
      nxt_ff.sync2 = cur_ff.sync1;
      nxt_ff.alt_in = '0;
      nxt_ff.main_in = '0;
      for (int unsigned p = 0; p < NUM_PADS; p++) begin
         if (take_first[p]) begin
            // Alternate owns the pad; main sees zero
            nxt_ff.pad_out[p] = I_ALT_OUT[p];
            nxt_ff.pad_oe[p] = I_ALT_OE[p];
            nxt_ff.pad_alt[p] = 1'b1;
            nxt_ff.alt_in[p] = cur_ff.sync2[p];
         end else if (p == PAD_UART_RTS && take_second) begin
            // Second alternate on the RTS pad
            nxt_ff.pad_out[p] = I_ALT_OUT[ALT_SPI_SELECT_TWO];
            nxt_ff.pad_oe[p] = I_ALT_OE[ALT_SPI_SELECT_TWO];
            nxt_ff.pad_alt[p] = 1'b1;
            nxt_ff.alt_in[ALT_SPI_SELECT_TWO] = cur_ff.sync2[p];
         end else begin
            // Main function owns the pad
            nxt_ff.pad_out[p] = I_MAIN_OUT[p];
            nxt_ff.pad_oe[p] = I_MAIN_OE[p];
            nxt_ff.pad_alt[p] = 1'b0;
            nxt_ff.main_in[p] = cur_ff.sync2[p];
         end
      end
   end

   // Routing state; pads released and main selected in reset
   always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Outputs straight from flip-flops
   assign O_PAD_OUT = cur_ff.pad_out;
   assign O_PAD_OE = cur_ff.pad_oe;
   assign O_PAD_ALT = cur_ff.pad_alt;
   assign O_MAIN_IN = cur_ff.main_in;
   assign O_ALT_IN = cur_ff.alt_in;
endmodule // pfm_pad_mux
`default_nettype wire

// ==== test/pfm_pad_mux_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_mux_props
   import pfm_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WRITE,
   input wire logic I_READ,
   input wire logic [DATA_W-1:0] O_RDATA,
   input wire logic [NUM_PADS-1:0] I_PAD_IN,
   input wire logic [NUM_PADS-1:0] O_PAD_OUT,
   input wire logic [NUM_PADS-1:0] O_PAD_OE,
   input wire logic [NUM_PADS-1:0] O_PAD_ALT,
   input wire logic [NUM_PADS-1:0] I_MAIN_OUT,
   input wire logic [NUM_PADS-1:0] I_MAIN_OE,
   input wire logic [NUM_PADS-1:0] O_MAIN_IN,
   input wire logic [NUM_ALTS-1:0] I_ALT_OUT,
   input wire logic [NUM_ALTS-1:0] I_ALT_OE,
   input wire logic [NUM_ALTS-1:0] O_ALT_IN
);
   logic [SEL_W-1:0] shadow_ff;
   logic [2:0] live_ff;
   logic clk_pad_exp;
   logic rts_pad_exp;
   logic clk_oe_exp;
   // Mirror of the select register and a count of edges since reset that stops at 7
   always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
         shadow_ff <= SEL_RESET;
         live_ff <= 3'h0;
      end else begin
         if (I_WRITE && I_ADDR == ADDR_PAD_FUNCTION_SELECT) begin
            shadow_ff <= I_WDATA[SEL_W-1:0];
         end
         if (live_ff != 3'h7) begin
            live_ff <= live_ff + 3'h1;
         end
      end
   end
   // Source that each checked pad should carry; RTS gives mode two priority
   assign clk_pad_exp = shadow_ff[28] ? I_ALT_OUT[0] : I_MAIN_OUT[0];
   assign rts_pad_exp = shadow_ff[27] ? I_ALT_OUT[1] :
      (shadow_ff[19] ? I_ALT_OUT[45] : I_MAIN_OUT[1]);
   assign clk_oe_exp = shadow_ff[28] ? I_ALT_OE[0] : I_MAIN_OE[0];
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RESET);
   sequence s_sel_read;
      I_READ && I_ADDR == ADDR_PAD_FUNCTION_SELECT;
   endsequence
   sequence s_routed;
      live_ff >= 3'h2;
   endsequence
   property p_read_value;
      s_sel_read |=> O_RDATA == {3'h0, shadow_ff};
   endproperty
   a_read_value: assert property (p_read_value)
      else $error("select readback differs from written value");
   property p_read_idle;
      !($past(I_READ) && $past(I_ADDR) == ADDR_PAD_FUNCTION_SELECT)
         |-> O_RDATA == RDATA_IDLE;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data nonzero outside a select read");
   property p_top_zero;
      O_RDATA[31:29] == 3'h0;
   endproperty
   a_top_zero: assert property (p_top_zero)
      else $error("reserved read bits not zero");
   property p_clock_pad;
      s_routed |-> O_PAD_OUT[0] == $past(clk_pad_exp);
   endproperty
   a_clock_pad: assert property (p_clock_pad)
      else $error("stream clock pad carries wrong source");
   property p_clock_pad_oe;
      s_routed |-> O_PAD_OE[0] == $past(clk_oe_exp);
   endproperty
   a_clock_pad_oe: assert property (p_clock_pad_oe)
      else $error("stream clock pad enable from wrong source");
   property p_rts_pad;
      s_routed |-> O_PAD_OUT[1] == $past(rts_pad_exp);
   endproperty
   a_rts_pad: assert property (p_rts_pad)
      else $error("request-to-send pad carries wrong source");
   property p_stream_alt;
      s_routed |-> {O_PAD_ALT[2], O_PAD_ALT[3], O_PAD_ALT[4]}
         == $past(shadow_ff[26:24]);
   endproperty
   a_stream_alt: assert property (p_stream_alt)
      else $error("stream pad status does not follow selects");
   property p_keypad_alt;
      s_routed |-> {O_PAD_ALT[33], O_PAD_ALT[34], O_PAD_ALT[35],
         O_PAD_ALT[36]} == $past(shadow_ff[11:8]);
   endproperty
   a_keypad_alt: assert property (p_keypad_alt)
      else $error("keypad drive pad status does not follow selects");
   property p_pad_in_main;
      (live_ff == 3'h7 && !shadow_ff[0]) [*4]
         |-> O_MAIN_IN[44] == $past(I_PAD_IN[44], 3);
   endproperty
   a_pad_in_main: assert property (p_pad_in_main)
      else $error("smartcard pad input not passed to main owner");
   property p_pad_in_nav;
      (live_ff == 3'h7 && shadow_ff[24]) [*4]
         |-> O_ALT_IN[4] == $past(I_PAD_IN[4], 3) && !O_MAIN_IN[4];
   endproperty
   a_pad_in_nav: assert property (p_pad_in_nav)
      else $error("stream data pad input not passed to navigation owner");
endmodule // pfm_pad_mux_props
bind pfm_pad_mux pfm_pad_mux_props u_props(.I_CLOCK(I_CLOCK),
   .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WRITE(I_WRITE), .I_READ(I_READ), .O_RDATA(O_RDATA),
   .I_PAD_IN(I_PAD_IN), .O_PAD_OUT(O_PAD_OUT), .O_PAD_OE(O_PAD_OE),
   .O_PAD_ALT(O_PAD_ALT), .I_MAIN_OUT(I_MAIN_OUT), .I_MAIN_OE(I_MAIN_OE),
   .O_MAIN_IN(O_MAIN_IN), .I_ALT_OUT(I_ALT_OUT), .I_ALT_OE(I_ALT_OE),
   .O_ALT_IN(O_ALT_IN));
`default_nettype wire

// ==== test/pfm_pad_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfm_pad_model
   import pfm_pkg::*;
(
   input wire logic [NUM_PADS-1:0] i_pad_out,
   input wire logic [NUM_PADS-1:0] i_pad_oe,
   input wire logic [NUM_PADS-1:0] i_ext_level,
   output logic [NUM_PADS-1:0] o_pad_level
);
   // Far side yields wherever the chip drives, so no pad floats
   assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_level);
endmodule // pfm_pad_model
`default_nettype wire

// ==== test/tb_pad_alternate_function_mux.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_pad_alternate_function_mux import pfm_pkg::*;;
   logic I_CLOCK, I_RESET, I_WRITE, I_READ;
   logic [ADDR_W-1:0] I_ADDR;
   logic [DATA_W-1:0] I_WDATA, O_RDATA, w;
   logic [NUM_PADS-1:0] lvl, O_PAD_OUT, O_PAD_OE, O_PAD_ALT, O_MAIN_IN;
   logic [NUM_PADS-1:0] I_MAIN_OUT, I_MAIN_OE, ext;
   logic [NUM_ALTS-1:0] I_ALT_OUT, I_ALT_OE, O_ALT_IN;
   logic [SEL_W-1:0] cur_sel;
   int bad_count, comparisons;
   localparam logic [ADDR_W-1:0] A = ADDR_PAD_FUNCTION_SELECT;
   pfm_pad_mux dut(.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA), .I_WRITE(I_WRITE), .I_READ(I_READ),
      .O_RDATA(O_RDATA), .I_PAD_IN(lvl), .O_PAD_OUT(O_PAD_OUT),
      .O_PAD_OE(O_PAD_OE), .O_PAD_ALT(O_PAD_ALT), .I_MAIN_OUT(I_MAIN_OUT),
      .I_MAIN_OE(I_MAIN_OE), .O_MAIN_IN(O_MAIN_IN), .I_ALT_OUT(I_ALT_OUT),
      .I_ALT_OE(I_ALT_OE), .O_ALT_IN(O_ALT_IN));
   pfm_pad_model u_pads(.i_pad_out(O_PAD_OUT), .i_pad_oe(O_PAD_OE),
      .i_ext_level(ext), .o_pad_level(lvl));
   // Clock at 4 ns
   initial begin
      I_CLOCK = 1'b0;
      forever #2 I_CLOCK = ~I_CLOCK;
   end
   task automatic end_of_test;
      if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [NUM_ALTS-1:0] e, g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Register bus accesses; a write leaves its strobe for the next task
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge I_CLOCK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WRITE <= 1'b1;
      I_READ <= 1'b0;
      if (a == A) cur_sel = d[SEL_W-1:0];
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge I_CLOCK);
      I_ADDR <= a;
      I_READ <= 1'b1;
      I_WRITE <= 1'b0;
      @(posedge I_CLOCK);
      I_READ <= 1'b0;
      #1 chk("read data", NUM_ALTS'(e), NUM_ALTS'(O_RDATA));
   endtask
   // Select bit that owns each pad
   function automatic logic sel_of(input logic [SEL_W-1:0] s, input int p);
      int b;
      if (p == 1) return s[27] | s[19];
      b = p == 0 ? 28 : p < 5 ? 28 - p : p < 7 ? 23 : p < 11 ? 22 :
         p < 13 ? 21 : p < 15 ? 20 : p == 15 ? 19 : p < 18 ? 18 :
         p < 28 ? 17 : p == 28 ? 16 : 44 - p;
      return s[b];
   endfunction
   // New random peripheral and pad levels, then compare the whole routing
   task automatic settle;
      logic [NUM_PADS-1:0] eo, eoe, ea, emi;
      logic [NUM_ALTS-1:0] eai;
      int x;
      logic l;
      @(posedge I_CLOCK);
      I_WRITE <= 1'b0;
      I_READ <= 1'b0;
      I_MAIN_OUT <= NUM_PADS'({$urandom, $urandom});
      I_MAIN_OE <= NUM_PADS'({$urandom, $urandom});
      I_ALT_OUT <= NUM_ALTS'({$urandom, $urandom});
      I_ALT_OE <= NUM_ALTS'({$urandom, $urandom});
      ext <= NUM_PADS'({$urandom, $urandom});
      repeat (6) @(posedge I_CLOCK);
      #1 eai = '0;
      for (int p = 0; p < NUM_PADS; p++) begin
         ea[p] = sel_of(cur_sel, p);
         x = (p == 1 && !cur_sel[27]) ? 45 : p;
         eo[p] = ea[p] ? I_ALT_OUT[x] : I_MAIN_OUT[p];
         eoe[p] = ea[p] ? I_ALT_OE[x] : I_MAIN_OE[p];
         l = eoe[p] ? eo[p] : ext[p];
         emi[p] = !ea[p] & l;
         if (ea[p]) eai[x] = l;
      end
      chk("pad out", NUM_ALTS'(eo), NUM_ALTS'(O_PAD_OUT));
      chk("pad oe", NUM_ALTS'(eoe), NUM_ALTS'(O_PAD_OE));
      chk("pad alt", NUM_ALTS'(ea), NUM_ALTS'(O_PAD_ALT));
      chk("main in", NUM_ALTS'(emi), NUM_ALTS'(O_MAIN_IN));
      chk("alt in", eai, O_ALT_IN);
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge I_CLOCK);
      bad_count++;
      end_of_test;
   end
   initial begin
      {I_RESET, I_WRITE, I_READ, I_ADDR, I_WDATA} = '0;
      I_RESET = 1'b1;
      {I_MAIN_OUT, I_MAIN_OE, I_ALT_OUT, I_ALT_OE, ext, cur_sel} = '0;
      bad_count = 0;
      comparisons = 0;
      void'($urandom(81798));
      repeat (6) @(posedge I_CLOCK);
      I_RESET <= 1'b0;
      rd(A, '0);
      settle;
      for (int i = 0; i < 29; i++) begin
         wr(A, DATA_W'(1) << i);
         rd(A, DATA_W'(1) << i);
         settle;
      end
      repeat (20) begin
         w = $urandom;
         wr(A, w);
         rd(A, {3'h0, w[28:0]});
         settle;
      end
      wr(A, 32'hFFFF_FFFF);
      rd(A, 32'h1FFF_FFFF);
      settle;
      wr(A + 32'h4, 32'h0000_0000);
      rd(A + 32'h4, '0);
      rd(A, 32'h1FFF_FFFF);
      @(posedge I_CLOCK);
      I_RESET <= 1'b1;
      cur_sel = '0;
      repeat (2) @(posedge I_CLOCK);
      I_RESET <= 1'b0;
      rd(A, '0);
      settle;
      end_of_test;
   end
endmodule // tb_pad_alternate_function_mux
`default_nettype wire
